/* rtl/crunit_core.sv */
// Execute logic for relative call, reset, returns and rotate.
// Assumes instr_valid is high in phase 0 of a new cycle and stack is external.
`timescale 1ns/1ps
`include "crunit_defines.svh"
module crunit_core
    import crunit_pkg::*;
#(
    parameter int PC_W = 21
)
(
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire logic [15:0]     instr,
    input  wire logic            instr_valid,
    input  wire logic            irq_low_active,
    input  wire logic            priority_enable,
    input  wire logic [PC_W-1:0] stack_top_entry,
    input  wire logic [7:0]      file_data,
    input  wire logic [7:0]      saved_accum_copy,
    input  wire logic [7:0]      saved_flags_copy,
    input  wire logic [3:0]      saved_bank_select,
    output logic [PC_W-1:0]      pc,
    output logic [7:0]           accum,
    output logic [7:0]           status_flags,
    output logic [3:0]           bank_select_reg,
    output logic                 high_priority_irq_enable,
    output logic                 low_priority_irq_enable,
    output logic                 stack_push,
    output logic [PC_W-1:0]      stack_push_data,
    output logic                 stack_pop,
    output logic                 file_write,
    output logic [7:0]           file_wdata,
    output logic                 soft_reset,
    output logic                 busy
);
    crunit_dec_if dec_bus ();

    crunit_decoder u_dec (
        .instr (instr),
        .dec   (dec_bus.dec)
    );

    function automatic logic [PC_W-1:0] rel_target(input logic [PC_W-1:0] base, input logic [10:0] n);
        logic [PC_W-1:0] ext;
        ext = {{(PC_W-11){n[10]}}, n};
        return base + PC_W'(`CRU_PC_STEP) + {ext[PC_W-2:0], 1'b0};
    endfunction

    crunit_state_t   state;
    crunit_state_t   next_state;
    crunit_op_t      op_hold;
    crunit_op_t      next_op_hold;
    logic            shadow_hold;
    logic            next_shadow_hold;
    logic [1:0]      phase;
    logic [1:0]      next_phase;
    logic [PC_W-1:0] next_pc;
    logic [7:0]      next_accum;
    logic [7:0]      next_status_flags;
    logic [3:0]      next_bank_select_reg;
    logic            next_high_priority_irq_enable;
    logic            next_low_priority_irq_enable;
    logic [7:0]      rot;
    logic            last_phase;

    assign last_phase = (phase == `CRU_LAST_PHASE);

    always_comb begin
        next_state                    = state;
        next_op_hold                  = op_hold;
        next_shadow_hold              = shadow_hold;
        next_phase                    = phase + 2'h1;
        next_pc                       = pc;
        next_accum                    = accum;
        next_status_flags             = status_flags;
        next_bank_select_reg          = bank_select_reg;
        next_high_priority_irq_enable = high_priority_irq_enable;
        next_low_priority_irq_enable  = low_priority_irq_enable;
        stack_push                    = 1'b0;
        stack_push_data               = pc + PC_W'(`CRU_PC_STEP);
        stack_pop                     = 1'b0;
        file_write                    = 1'b0;
        file_wdata                    = 8'h00;
        soft_reset                    = 1'b0;
        rot                           = {file_data[6:0], status_flags[`CRU_STATUS_C]};
        busy                          = (state == CRU_IDLE);
        case (state)
            CRU_EXEC: begin
                if (instr_valid && phase == 2'h0) begin
                    next_op_hold     = dec_bus.op;
                    next_shadow_hold = dec_bus.shadow;
                    if (dec_bus.op == CRU_OP_RELATIVE_CALL_OP) begin
                        stack_push = 1'b1;
                    end
                    if (dec_bus.op == CRU_OP_RESET) begin
                        soft_reset = 1'b1;
                    end
                    if (dec_bus.op == CRU_OP_ROTATE_LEFT_CARRY_OP) begin
                        next_status_flags[`CRU_STATUS_C] = file_data[7];
                        next_status_flags[`CRU_STATUS_N] = rot[7];
                        next_status_flags[`CRU_STATUS_Z] = (rot == 8'h00);
                        if (dec_bus.dest) begin
                            file_write = 1'b1;
                            file_wdata = rot;
                        end else begin
                            next_accum = rot;
                        end
                    end
                end
                if (last_phase) begin
                    case (op_hold)
                        CRU_OP_RELATIVE_CALL_OP: begin
                            next_pc    = rel_target(pc, dec_bus.offset);
                            next_state = CRU_IDLE;
                        end
                        CRU_OP_INTERRUPT_RETURN_OP, CRU_OP_RETURN, CRU_OP_LITERAL_RETURN_OP: begin
                            stack_pop  = 1'b1;
                            next_pc    = stack_top_entry;
                            next_state = CRU_IDLE;
                            if (op_hold == CRU_OP_LITERAL_RETURN_OP) begin
                                next_accum = dec_bus.literal;
                            end else if (shadow_hold) begin
                                next_accum           = saved_accum_copy;
                                next_status_flags    = saved_flags_copy;
                                next_bank_select_reg = saved_bank_select;
                            end
                            if (op_hold == CRU_OP_INTERRUPT_RETURN_OP) begin
                                if (priority_enable && irq_low_active) begin
                                    next_low_priority_irq_enable = 1'b1;
                                end else begin
                                    next_high_priority_irq_enable = 1'b1;
                                end
                            end
                        end
                        CRU_OP_ROTATE_LEFT_CARRY_OP, CRU_OP_NONE: begin
                            next_pc = pc + PC_W'(`CRU_PC_STEP);
                        end
                        default: begin
                            next_pc = pc;
                        end
                    endcase
                    next_op_hold = CRU_OP_NONE;
                end
            end
            CRU_IDLE: begin
                if (last_phase) begin
                    next_state = CRU_EXEC;
                end
            end
            default: begin
                next_state = CRU_EXEC;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state                    <= CRU_EXEC;
            op_hold                  <= CRU_OP_NONE;
            shadow_hold              <= 1'b0;
            phase                    <= 2'h0;
            pc                       <= PC_W'(`CRU_PC_RESET);
            accum                    <= 8'h00;
            status_flags             <= 8'h00;
            bank_select_reg          <= 4'h0;
            high_priority_irq_enable <= 1'b0;
            low_priority_irq_enable  <= 1'b0;
        end else begin
            state                    <= next_state;
            op_hold                  <= next_op_hold;
            shadow_hold              <= next_shadow_hold;
            phase                    <= next_phase;
            pc                       <= next_pc;
            accum                    <= next_accum;
            status_flags             <= next_status_flags;
            bank_select_reg          <= next_bank_select_reg;
            high_priority_irq_enable <= next_high_priority_irq_enable;
            low_priority_irq_enable  <= next_low_priority_irq_enable;
        end
    end
endmodule

/* rtl/crunit_defines.svh */
// Constants for the call and return instruction unit.
// Assumes a 16-bit instruction word and a 21-bit program counter.
// How it works
// - Relative call is 11011 plus 11-bit offset
// - Offset is signed, -1024 to 1023 words
// - Call pushes PC+2, jumps PC+2+2n, two cycles
// - Reset opcode starts full master clear reset
// - Interrupt return pops stack into PC, two cycles
// - Interrupt return sets enable in final phase
// - Shadow bit set restores accumulator, flags, bank
// - Returns leave PC high latches untouched
// - Literal return loads accumulator, pops PC
// - Subroutine return pops PC, keeps flags unless shadow bit set, idles
// - Rotate left through carry updates C, N, Z
// - Destination bit picks accumulator or file register
`ifndef CRUNIT_DEFINES_SVH
`define CRUNIT_DEFINES_SVH

`define CRU_RELATIVE_CALL_OP_PREFIX  5'h1b
`define CRU_RESET_OPCODE  16'h00ff
`define CRU_INTERRUPT_RETURN_OP_PREFIX 15'h0008
`define CRU_RETURN_PREFIX 15'h0009
`define CRU_LITERAL_RETURN_OP_PREFIX  8'h0c
`define CRU_ROTATE_LEFT_CARRY_OP_PREFIX   6'h0d
`define CRU_PC_STEP       21'h000002
`define CRU_PC_RESET      21'h000000
`define CRU_STATUS_C      0
`define CRU_STATUS_Z      2
`define CRU_STATUS_N      4
`define CRU_PHASES        4
`define CRU_LAST_PHASE    2'h3

`endif

/* rtl/crunit_pkg.sv */
// Types for the call and return instruction unit.
// Assumes the defines header is included by users.
package crunit_pkg;
    typedef enum logic [2:0] {
        CRU_OP_NONE,
        CRU_OP_RELATIVE_CALL_OP,
        CRU_OP_RESET,
        CRU_OP_INTERRUPT_RETURN_OP,
        CRU_OP_RETURN,
        CRU_OP_LITERAL_RETURN_OP,
        CRU_OP_ROTATE_LEFT_CARRY_OP
    } crunit_op_t;
    typedef enum {
        CRU_EXEC,
        CRU_IDLE
    } crunit_state_t;
endpackage

/* rtl/crunit_dec_if.sv */
// Decoded instruction fields passed from decoder to core.
// Assumes one decoder and one consumer.
`timescale 1ns/1ps
interface crunit_dec_if;
    import crunit_pkg::*;
    crunit_op_t  op;
    logic [10:0] offset;
    logic        shadow;
    logic [7:0]  literal;
    logic        dest;
    modport dec  (output op, output offset, output shadow, output literal, output dest);
    modport core (input op, input offset, input shadow, input literal, input dest);
endinterface

/* rtl/crunit_decoder.sv */
// Opcode decoder for the call and return group.
// Assumes a stable instruction word during decode.
`timescale 1ns/1ps
`include "crunit_defines.svh"
module crunit_decoder
    import crunit_pkg::*;
(
    input  wire logic [15:0] instr,
    crunit_dec_if.dec        dec
);
    always_comb begin
        dec.op      = CRU_OP_NONE;
        dec.offset  = instr[10:0];
        dec.shadow  = instr[0];
        dec.literal = instr[7:0];
        dec.dest    = instr[9];
        if (instr[15:11] == `CRU_RELATIVE_CALL_OP_PREFIX) begin
            dec.op = CRU_OP_RELATIVE_CALL_OP;
        end else if (instr == `CRU_RESET_OPCODE) begin
            dec.op = CRU_OP_RESET;
        end else if (instr[15:1] == `CRU_INTERRUPT_RETURN_OP_PREFIX) begin
            dec.op = CRU_OP_INTERRUPT_RETURN_OP;
        end else if (instr[15:1] == `CRU_RETURN_PREFIX) begin
            dec.op = CRU_OP_RETURN;
        end else if (instr[15:8] == `CRU_LITERAL_RETURN_OP_PREFIX) begin
            dec.op = CRU_OP_LITERAL_RETURN_OP;
        end else if (instr[15:10] == `CRU_ROTATE_LEFT_CARRY_OP_PREFIX) begin
            dec.op = CRU_OP_ROTATE_LEFT_CARRY_OP;
        end
    end
endmodule

/* verification/crunit_properties.sv */
// Checker for the call and return unit, bound to every crunit_core.
// Assumes only the core's ports; one clock, async active-high reset.
`timescale 1ns/1ps
module crunit_properties
    import crunit_pkg::*;
#(
    parameter int PC_W = 21
)
(
    input wire logic            clk,
    input wire logic            rst,
    input wire logic [15:0]     instr,
    input wire logic            instr_valid,
    input wire logic            irq_low_active,
    input wire logic            priority_enable,
    input wire logic [PC_W-1:0] stack_top_entry,
    input wire logic [7:0]      file_data,
    input wire logic [7:0]      saved_accum_copy,
    input wire logic [7:0]      saved_flags_copy,
    input wire logic [3:0]      saved_bank_select,
    input wire logic [PC_W-1:0] pc,
    input wire logic [7:0]      accum,
    input wire logic [7:0]      status_flags,
    input wire logic [3:0]      bank_select_reg,
    input wire logic            high_priority_irq_enable,
    input wire logic            low_priority_irq_enable,
    input wire logic            stack_push,
    input wire logic [PC_W-1:0] stack_push_data,
    input wire logic            stack_pop,
    input wire logic            file_write,
    input wire logic [7:0]      file_wdata,
    input wire logic            soft_reset,
    input wire logic            busy
);
    logic [PC_W-1:0] call_target;
    logic            shadow_ret;
    logic            want_low;
    assign call_target = stack_push_data + {{(PC_W-12){instr[10]}}, instr[10:0], 1'b0};
    assign shadow_ret  = stack_pop && (instr[15:1] == 15'h0008 || instr[15:1] == 15'h0009);
    assign want_low    = priority_enable && irq_low_active;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence call_start;
        stack_push && instr[15:11] == 5'h1b;
    endsequence
    sequence idle_cycle;
        busy [*4] ##1 !busy;
    endsequence
    push_decode_a: assert property (stack_push |-> instr[15:11] == 5'h1b && !busy)
        else $error("push outside a call");
    push_data_a: assert property (stack_push |-> stack_push_data == pc + 21'h000002)
        else $error("pushed address wrong");
    call_jump_a: assert property (call_start |-> ##4 pc == $past(call_target, 4))
        else $error("call target wrong");
    call_idle_a: assert property (call_start |-> ##4 idle_cycle)
        else $error("call idle cycle wrong");
    pop_pc_a: assert property (stack_pop |=> pc == $past(stack_top_entry) ##0 idle_cycle)
        else $error("return target or idle wrong");
    shadow_load_a: assert property (shadow_ret && instr[0] |=> accum == $past(saved_accum_copy)
        && status_flags == $past(saved_flags_copy) && bank_select_reg == $past(saved_bank_select))
        else $error("shadow restore wrong");
    shadow_keep_a: assert property (shadow_ret && !instr[0] |=> $stable(accum) && $stable(status_flags)
        && $stable(bank_select_reg)) else $error("registers changed without shadow");
    irq_enable_a: assert property (stack_pop && instr[15:1] == 15'h0008 |=>
        (want_low ? low_priority_irq_enable : high_priority_irq_enable)) else $error("enable not set");
    rotate_data_a: assert property (file_write |-> file_wdata == {file_data[6:0], status_flags[0]})
        else $error("rotate result wrong");
    soft_reset_a: assert property (soft_reset |-> instr == 16'h00ff && !busy)
        else $error("reset pulse without opcode");
endmodule

bind crunit_core crunit_properties #(.PC_W(PC_W)) crunit_properties_i (.*);

/* verification/crunit_tb.sv */
// Self-checking bench for crunit_core: calls, returns, rotate, soft reset.
// Assumes the bench plays stack, file register and shadow registers.
`timescale 1ns/1ps
module tb;
    import crunit_pkg::*;
    logic        clk, rst, instr_valid, irq_low_active, priority_enable, soft_reset, busy;
    logic        high_priority_irq_enable, low_priority_irq_enable, stack_push, stack_pop, file_write;
    logic        peek_write, peek_soft;
    logic [15:0] instr;
    logic [20:0] stack_top_entry, pc, stack_push_data, peek_push;
    logic [7:0]  file_data, saved_accum_copy, saved_flags_copy, accum, status_flags, file_wdata, peek_wdata;
    logic [3:0]  saved_bank_select, bank_select_reg;
    int          errors, samples_checked;
    crunit_core crunit_core_i (.*);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic do_reset();
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
    endtask
    task automatic run(input logic [15:0] op, input int cycles);
        instr       <= op;
        instr_valid <= 1'b1;
        #1;
        peek_push  = stack_push_data;
        peek_write = file_write;
        peek_wdata = file_wdata;
        peek_soft  = soft_reset;
        @(posedge clk);
        instr_valid <= 1'b0;
        repeat (4 * cycles - 1) @(posedge clk);
        #1;
    endtask
    task automatic test_calls();
        run(16'hdbff, 2);
        check(peek_push, 21'h000002);
        check(pc, 21'h000800);
        run(16'hdc00, 2);
        check(pc, 21'h000002);
        run(16'hd800, 1);
        check(busy, 1'b1);
        run(16'h0c77, 1);
        check(accum, 8'h00);
        check(pc, 21'h000004);
    endtask
    task automatic rot(input logic [15:0] op, input logic [7:0] fd, input logic cin, input logic [7:0] acc,
                       input logic [7:0] st);
        file_data <= fd;
        run(op, 1);
        check(peek_write, op[9]);
        if (op[9]) check(peek_wdata, {fd[6:0], cin});
        check(accum, acc);
        check(status_flags, st);
    endtask
    task automatic test_returns();
        stack_top_entry   <= 21'h012344;
        saved_accum_copy  <= 8'h5a;
        saved_flags_copy  <= 8'h00;
        saved_bank_select <= 4'h9;
        priority_enable   <= 1'b1;
        irq_low_active    <= 1'b1;
        run(16'h0011, 2);
        check(pc, 21'h012344);
        check({accum, status_flags, bank_select_reg}, {8'h5a, 8'h00, 4'h9});
        check({low_priority_irq_enable, high_priority_irq_enable}, 2'h2);
        rot(16'h3610, 8'h81, 1'b0, 8'h5a, 8'h01);
        rot(16'h3410, 8'h40, 1'b1, 8'h81, 8'h10);
        rot(16'h3410, 8'h80, 1'b0, 8'h00, 8'h05);
        stack_top_entry <= 21'h000abc;
        run(16'h0ca5, 2);
        check({pc, accum}, {21'h000abc, 8'ha5});
        stack_top_entry <= 21'h01fffe;
        run(16'h0012, 2);
        check({pc, accum, status_flags}, {21'h01fffe, 8'ha5, 8'h05});
        priority_enable <= 1'b0;
        run(16'h0010, 2);
        check({high_priority_irq_enable, bank_select_reg}, {1'b1, 4'h9});
    endtask
    task automatic test_soft_reset();
        run(16'h00ff, 1);
        check(peek_soft, 1'b1);
        do_reset();
        #1;
        check({pc, accum, high_priority_irq_enable, low_priority_irq_enable}, 31'h0);
    endtask
    task automatic final_report();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #5000;
        errors++;
        final_report();
    end
    initial begin
        {rst, instr_valid, irq_low_active, priority_enable, instr, stack_top_entry} = '0;
        {file_data, saved_accum_copy, saved_flags_copy, saved_bank_select} = '0;
        do_reset();
        test_calls();
        test_returns();
        test_soft_reset();
        final_report();
    end
endmodule
